//--- rtl/vrs_pkg.sv
// Purpose: shared constants and types of the vibration record store and readout
// Assumes: 16-bit registers addressed by byte offset on the serial register port
// Notes:   one page of the register map only; paging is handled outside
package vrs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_TEMPERATURE_READING = 7'h02;
  localparam logic [6:0] ADDR_SUPPLY_READING = 7'h04;
  localparam logic [6:0] ADDR_BUFFER_INDEX = 7'h0A;
  localparam logic [6:0] ADDR_RECORD_SELECTOR = 7'h0C;
  localparam logic [6:0] ADDR_X_SAMPLE_OUT = 7'h0E;
  localparam logic [6:0] ADDR_Y_SAMPLE_OUT = 7'h10;
  localparam logic [6:0] ADDR_Z_SAMPLE_OUT = 7'h12;
  localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h3E;
  localparam logic [6:0] ADDR_TIMESTAMP_LOW = 7'h4C;
  localparam logic [6:0] ADDR_TIMESTAMP_HIGH = 7'h4E;
  localparam logic [6:0] ADDR_RECORD_HEADER_FIRST = 7'h66;
  localparam logic [6:0] ADDR_RECORD_HEADER_SECOND = 7'h68;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int IDX_W = 12;
  localparam int SLOT_W = 4;
  localparam int STAT_W = 5;
  localparam int ARCH_AW = SLOT_W + 11;
  localparam int TIME_DEPTH = 4096;
  localparam int SPEC_DEPTH = 2048;
  localparam int NUM_SPEC_REC = 10;
  localparam int NUM_STAT_REC = 32;
  localparam logic [IDX_W-1:0] TIME_LAST = 12'hFFF;
  localparam logic [IDX_W-1:0] SPEC_LAST = 12'h7FF;
  localparam logic [15:0] SAMPLE_RESET = 16'h8000;
  localparam logic [IDX_W-1:0] INDEX_RESET = 12'h000;
  localparam logic [15:0] SELECTOR_RESET = 16'h0000;
  localparam logic [15:0] SELECTOR_MASK = 16'h1F0F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POLICY_LSB = 2;
  localparam int CTRL_VELOCITY_BIT = 5;
  localparam int CTRL_STATS_BIT = 6;
  localparam int CTRL_RSS_BIT = 8;
  localparam int GCMD_RESTORE_BIT = 13;
  localparam int SEL_SPEC_LSB = 0;
  localparam int SEL_STAT_LSB = 8;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_MANUAL_SPECTRAL = 2'h0;
  localparam logic [1:0] MODE_AUTOMATIC_SPECTRAL = 2'h1;
  localparam logic [1:0] MODE_TIME_CAPTURE = 2'h2;
  localparam logic [1:0] MODE_STREAMING = 2'h3;
  localparam logic [1:0] POLICY_LATEST = 2'h0;
  localparam logic [1:0] POLICY_ALARM = 2'h1;
  localparam logic [1:0] POLICY_ALL = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ARCHIVE, ST_RESTORE, ST_LOAD} vrs_state_t;

endpackage

//--- rtl/vrs_axis_if.sv
// Purpose: ports of one axis store, working buffer plus archive
// Assumes: reads are combinational, writes take the clock edge
// Notes:   ctrl side drives addresses and enables, store side answers data
`timescale 1ns/1ns
interface vrs_axis_if;
  import vrs_pkg::*;
  logic live_we;
  logic [IDX_W-1:0] live_waddr;
  logic [15:0] live_wdata;
  logic [IDX_W-1:0] live_raddr;
  logic [15:0] live_rdata;
  logic arch_we;
  logic [ARCH_AW-1:0] arch_waddr;
  logic [15:0] arch_wdata;
  logic [ARCH_AW-1:0] arch_raddr;
  logic [15:0] arch_rdata;
  modport store (input live_we, live_waddr, live_wdata, live_raddr, arch_we, arch_waddr, arch_wdata,
                 arch_raddr, output live_rdata, arch_rdata);
  modport ctrl (output live_we, live_waddr, live_wdata, live_raddr, arch_we, arch_waddr, arch_wdata,
                arch_raddr, input live_rdata, arch_rdata);
endinterface

//--- rtl/vrs_axis_store.sv
// Purpose: one axis of record storage
// Assumes: caller keeps addresses inside the arrays and gates writes with the clock enable
// Notes:   arrays have no reset; contents are defined only after a record is written
`timescale 1ns/1ns
module vrs_axis_store
  import vrs_pkg::*;
#(
  parameter int DEPTH = TIME_DEPTH,
  parameter int ARCH_DEPTH = NUM_SPEC_REC * SPEC_DEPTH
) (
  input wire logic clk_sys,
  vrs_axis_if.store port
);

  // ----------------------------------------------------------------
  // working record and archived records
  // ----------------------------------------------------------------
  // working capture memory is volatile; the archive stands in for flash
  logic [15:0] live_mem [DEPTH];
  logic [15:0] arch_mem [ARCH_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (port.live_we) begin
      live_mem[port.live_waddr] <= port.live_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (port.arch_we) begin
      arch_mem[port.arch_waddr] <= port.arch_wdata;
    end
  end

  assign port.live_rdata = live_mem[port.live_raddr];
  assign port.arch_rdata = arch_mem[port.arch_raddr];

endmodule

//--- rtl/vrs_record_store.sv
// Purpose: record storage policies and indexed buffer readout for three axes
// Assumes: acquisition, statistics, alarm evaluation and serial framing sit upstream
// Notes:   register reads answer one cycle after the strobe
`timescale 1ns/1ns

// Behaviour
// - three storage policies: latest only, alarm records only, every record.
// - latest policy keeps only the newest record in the working buffer.
// - alarm policy archives header and spectral data only for alarming records.
// - an alarm on any axis archives all three axes.
// - all policy archives every spectral-mode record; ten spectral slots kept.
// - time mode archives statistics headers, never raw samples.
// - records hold 4096 time samples or 2048 spectral bins per axis.
// - record completion zeroes the index and loads entry 0 of each axis.
// - host writes the index; entries at that index are loaded.
// - each sample register read advances the index up to the last entry and loads next entries.
// - index is bits 11:0, upper bits unused, reset zero.
// - selector holds statistic slot in 12:8 and spectral slot in 3:0.
// - command bit 13 restores the selected spectral record.
// - order: store and next rate profile together, then archive per policy, then busy.
// - time data is 16-bit two's complement acceleration.
// - velocity select bit 5 stores velocity instead of acceleration.
// - statistics enable bit 6 in time mode archives the statistics record.
// - with rss in time mode, z buffer holds rss; x and y own samples.
// - x and y alarms own axes, z alarm judged on rss values.
// - sample registers read-only, reset 0x8000.
// - working captures volatile, archived records kept in separate store.
// - mode field 00 manual spectral, 01 automatic spectral, 11 streaming.
// - busy low while processing, high once data is ready.
module vrs_record_store
  import vrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [15:0] record_control,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] supply_in,
  input wire logic cap_start,
  input wire logic cap_we,
  input wire logic [IDX_W-1:0] cap_index,
  input wire logic [2:0][15:0] cap_accel,
  input wire logic [2:0][15:0] cap_vel,
  input wire logic [15:0] cap_rss,
  input wire logic rec_done,
  input wire logic [2:0] rec_alarm,
  input wire logic [15:0] hdr_word1,
  input wire logic [15:0] hdr_word2,
  input wire logic [31:0] rec_stamp,
  input wire logic [1:0] profile_count,
  output logic busy,
  output logic [1:0] profile_sel,
  output logic [2:0] alarm_flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vrs_state_t state;
  logic [IDX_W-1:0] cnt;
  logic [IDX_W-1:0] buf_index;
  logic [15:0] selector;
  logic [15:0] sample_out [3];
  logic [SLOT_W-1:0] wr_slot;
  logic [STAT_W-1:0] stat_slot;
  logic live_is_time;
  logic [15:0] hdr_first;
  logic [15:0] hdr_second;
  logic [31:0] hdr_stamp;
  logic [15:0] spec_first [NUM_SPEC_REC];
  logic [15:0] spec_second [NUM_SPEC_REC];
  logic [31:0] spec_stamp [NUM_SPEC_REC];
  logic [15:0] stat_first [NUM_STAT_REC];
  logic [15:0] stat_second [NUM_STAT_REC];
  logic [31:0] stat_stamp [NUM_STAT_REC];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] policy;
  logic time_mode;
  logic want_archive;
  logic want_stat;
  logic sample_read;
  logic index_write;
  logic restore_cmd;
  logic [SLOT_W-1:0] sel_spec;
  logic [STAT_W-1:0] sel_stat;
  logic [IDX_W-1:0] last_index;
  logic [IDX_W-1:0] next_index;
  logic load_en;

  assign mode = record_control[CTRL_MODE_LSB +: 2];
  assign policy = record_control[CTRL_POLICY_LSB +: 2];
  assign time_mode = (mode == MODE_TIME_CAPTURE);
  // any axis alarm keeps the whole record, all axes together
  assign want_archive = !time_mode && (mode != MODE_STREAMING) &&
                        ((policy == POLICY_ALL) || ((policy == POLICY_ALARM) && (|rec_alarm)));
  // raw time samples are never archived, only the statistics header
  assign want_stat = time_mode && record_control[CTRL_STATS_BIT] &&
                     ((policy == POLICY_ALL) || ((policy == POLICY_ALARM) && (|rec_alarm)));
  assign sample_read = reg_rd && ((reg_addr == ADDR_X_SAMPLE_OUT) || (reg_addr == ADDR_Y_SAMPLE_OUT) ||
                                  (reg_addr == ADDR_Z_SAMPLE_OUT));
  assign index_write = reg_wr && (reg_addr == ADDR_BUFFER_INDEX);
  assign sel_spec = selector[SEL_SPEC_LSB +: SLOT_W];
  assign sel_stat = selector[SEL_STAT_LSB +: STAT_W];
  assign restore_cmd = reg_wr && (reg_addr == ADDR_GLOBAL_COMMAND) && reg_wdata[GCMD_RESTORE_BIT] &&
                       (sel_spec < SLOT_W'(NUM_SPEC_REC));
  assign last_index = live_is_time ? TIME_LAST : SPEC_LAST;

  // ----------------------------------------------------------------
  // index steering
  // ----------------------------------------------------------------
  always_comb begin
    next_index = buf_index;
    load_en = 1'b0;
    if (state == ST_LOAD) begin
      next_index = INDEX_RESET;
      load_en = 1'b1;
    end else if (state == ST_IDLE) begin
      if (index_write) begin
        // upper bits dropped; out-of-range values pin to the last entry
        if (reg_wdata[IDX_W-1:0] > last_index) begin
          next_index = last_index;
        end else begin
          next_index = reg_wdata[IDX_W-1:0];
        end
        load_en = 1'b1;
      end else if (sample_read) begin
        if (buf_index < last_index) begin
          next_index = buf_index + 12'h001;
        end else begin
          next_index = last_index;
        end
        load_en = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axis stores
  // ----------------------------------------------------------------
  vrs_axis_if ax_bus [3] ();
  logic [15:0] ax_rdata [3];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic [15:0] cap_word;
      // velocity replaces acceleration; rss replaces z in time mode
      always_comb begin
        cap_word = record_control[CTRL_VELOCITY_BIT] ? cap_vel[g] : cap_accel[g];
        if ((g == 2) && time_mode && record_control[CTRL_RSS_BIT]) begin
          cap_word = cap_rss;
        end
      end
      assign ax_bus[g].live_we = ce && ((state == ST_RESTORE) || ((state == ST_IDLE) && cap_we));
      assign ax_bus[g].live_waddr = (state == ST_RESTORE) ? cnt : cap_index;
      assign ax_bus[g].live_wdata = (state == ST_RESTORE) ? ax_bus[g].arch_rdata : cap_word;
      assign ax_bus[g].live_raddr = (state == ST_ARCHIVE) ? cnt : next_index;
      assign ax_bus[g].arch_we = ce && (state == ST_ARCHIVE);
      assign ax_bus[g].arch_waddr = {wr_slot, cnt[10:0]};
      assign ax_bus[g].arch_wdata = ax_bus[g].live_rdata;
      assign ax_bus[g].arch_raddr = {sel_spec, cnt[10:0]};
      assign ax_rdata[g] = ax_bus[g].live_rdata;
      vrs_axis_store #(
        .DEPTH(TIME_DEPTH),
        .ARCH_DEPTH(NUM_SPEC_REC * SPEC_DEPTH)
      ) u_store (
        .clk_sys(clk_sys),
        .port(ax_bus[g].store)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= INDEX_RESET;
      wr_slot <= '0;
      stat_slot <= '0;
      live_is_time <= 1'b0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          cnt <= INDEX_RESET;
          if (rec_done) begin
            live_is_time <= time_mode;
            if (want_stat) begin
              stat_slot <= stat_slot + 5'h01;
            end
            // latest policy leaves the record in the working buffer only
            state <= want_archive ? ST_ARCHIVE : ST_LOAD;
          end else if (restore_cmd) begin
            state <= ST_RESTORE;
          end
        end
        ST_ARCHIVE: begin
          cnt <= cnt + 12'h001;
          if (cnt == SPEC_LAST) begin
            // oldest slot is overwritten once all ten are used
            wr_slot <= (wr_slot == SLOT_W'(NUM_SPEC_REC - 1)) ? '0 : wr_slot + 4'h1;
            state <= ST_LOAD;
          end
        end
        ST_RESTORE: begin
          cnt <= cnt + 12'h001;
          if (cnt == SPEC_LAST) begin
            live_is_time <= 1'b0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // record headers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hdr_first <= 16'h0000;
      hdr_second <= 16'h0000;
      hdr_stamp <= 32'h00000000;
    end else if (ce) begin
      if ((state == ST_IDLE) && rec_done) begin
        hdr_first <= hdr_word1;
        hdr_second <= hdr_word2;
        hdr_stamp <= rec_stamp;
      end else if ((state == ST_RESTORE) && (cnt == SPEC_LAST)) begin
        hdr_first <= spec_first[sel_spec];
        hdr_second <= spec_second[sel_spec];
        hdr_stamp <= spec_stamp[sel_spec];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && (state == ST_ARCHIVE) && (cnt == SPEC_LAST)) begin
      spec_first[wr_slot] <= hdr_first;
      spec_second[wr_slot] <= hdr_second;
      spec_stamp[wr_slot] <= hdr_stamp;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && (state == ST_IDLE) && rec_done && want_stat) begin
      stat_first[stat_slot] <= hdr_word1;
      stat_second[stat_slot] <= hdr_word2;
      stat_stamp[stat_slot] <= rec_stamp;
    end
  end

  // ----------------------------------------------------------------
  // alarms, rate profile and busy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alarm_flags <= 3'h0;
      profile_sel <= 2'h0;
    end else if (ce && (state == ST_IDLE) && rec_done) begin
      // z flag arrives already judged against rss when rss is on
      alarm_flags <= rec_alarm;
      profile_sel <= (profile_sel >= profile_count) ? 2'h0 : profile_sel + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy <= 1'b1;
    end else if (ce) begin
      if (state == ST_LOAD) begin
        busy <= 1'b1;
      end else if ((state == ST_IDLE) && (cap_start || rec_done || restore_cmd)) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // index, selector and sample registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      buf_index <= INDEX_RESET;
    end else if (ce) begin
      buf_index <= next_index;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      selector <= SELECTOR_RESET;
    end else if (ce && reg_wr && (reg_addr == ADDR_RECORD_SELECTOR)) begin
      selector <= reg_wdata & SELECTOR_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int a = 0; a < 3; a++) begin
        sample_out[a] <= SAMPLE_RESET;
      end
    end else if (ce && load_en) begin
      for (int a = 0; a < 3; a++) begin
        sample_out[a] <= ax_rdata[a];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // sample registers answer the value held before the advance
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_TEMPERATURE_READING: reg_rdata <= temp_in;
          ADDR_SUPPLY_READING: reg_rdata <= supply_in;
          ADDR_BUFFER_INDEX: reg_rdata <= {4'h0, buf_index};
          ADDR_RECORD_SELECTOR: reg_rdata <= selector;
          ADDR_X_SAMPLE_OUT: reg_rdata <= sample_out[0];
          ADDR_Y_SAMPLE_OUT: reg_rdata <= sample_out[1];
          ADDR_Z_SAMPLE_OUT: reg_rdata <= sample_out[2];
          ADDR_TIMESTAMP_LOW: reg_rdata <= hdr_stamp[15:0];
          ADDR_TIMESTAMP_HIGH: reg_rdata <= hdr_stamp[31:16];
          ADDR_RECORD_HEADER_FIRST: reg_rdata <= (time_mode ? stat_first[sel_stat] : hdr_first);
          ADDR_RECORD_HEADER_SECOND: reg_rdata <= (time_mode ? stat_second[sel_stat] : hdr_second);
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

//--- tb/vrs_record_store_chk.sv
// Purpose: port checks of the record store
// Assumes: one clock, srst synchronous active high
// Notes: waits are bounded by the 2048-bin copy plus load
`timescale 1ns/1ns
module vrs_record_store_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic cap_start,
  input wire logic rec_done,
  input wire logic [2:0] rec_alarm,
  input wire logic [1:0] profile_count,
  input wire logic busy,
  input wire logic [1:0] profile_sel,
  input wire logic [2:0] alarm_flags
);
  // a busy low run not opened by cap_start must end after the archive copy and load
  logic [11:0] low_run;
  logic by_cap;
  always_ff @(posedge clk_sys) begin
    if (srst || busy) begin
      low_run <= 12'h000;
    end else if (ce && !by_cap && low_run != 12'hFFF) begin
      low_run <= low_run + 12'h001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      by_cap <= 1'b0;
    end else if (ce && busy) begin
      by_cap <= cap_start;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  reset_values_a: assert property (disable iff (1'b0) srst && ce |=> busy && !reg_rvalid && profile_sel == 2'h0)
    else $error("reset values wrong");
  read_answer_a: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  lone_answer_a: assert property (ce && !reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property (ce && !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  done_fall_a: assert property (ce && rec_done && busy |=> !busy)
    else $error("busy did not fall");
  alarm_copy_a: assert property (ce && rec_done && busy |=> alarm_flags == $past(rec_alarm))
    else $error("alarm flags wrong");
  profile_step_a: assert property (ce && rec_done && busy |=> profile_sel ==
    (($past(profile_sel) >= $past(profile_count)) ? 2'h0 : 2'($past(profile_sel) + 2'h1)))
    else $error("profile not advanced");
  ready_bound_a: assert property (low_run <= 12'h80C)
    else $error("busy stuck low");
  busy_hold_a: assert property (busy && !rec_done && !cap_start && !reg_wr |=> busy)
    else $error("busy fell alone");
  cover property (ce && reg_rd);
  cover property ($rose(busy));
  cover property (rec_done && rec_alarm != 3'h0);
endmodule
bind vrs_record_store vrs_record_store_chk u_vrs_record_store_chk (.clk_sys(clk_sys), .srst(srst), .ce(ce),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cap_start(cap_start),
  .rec_done(rec_done), .rec_alarm(rec_alarm), .profile_count(profile_count), .busy(busy),
  .profile_sel(profile_sel), .alarm_flags(alarm_flags));

//--- tb/vrs_host_model.sv
// Purpose: host on the register port of the record store
// Assumes: one strobe per access, read answered one cycle later
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module vrs_host_model (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
  // buffers are only touched once busy is back high, so the record is whole
  task automatic wait_ready(output int n);
    n = 0;
    @(posedge clk_sys);
    while (busy !== 1'b1 && n < 3000) begin
      n++;
      @(posedge clk_sys);
    end
  endtask
endmodule

//--- tb/tb_vrs_record_store.sv
// Purpose: self-checking bench of the record store
// Assumes: ce held high, records written sparsely at bins 0, 1 and 4095
// Notes: archive slots are taken to fill from slot 0
`timescale 1ns/1ns
module tb_vrs_record_store
  import vrs_pkg::*;
();
  logic clk_sys = 1'b0;
  logic srst, ce, cap_start, cap_we, rec_done, reg_wr, reg_rd, reg_rvalid, busy;
  logic [15:0] record_control, temp_in, supply_in, cap_rss, hdr_word1, hdr_word2, reg_wdata, reg_rdata;
  logic [11:0] cap_index;
  logic [2:0][15:0] cap_accel, cap_vel;
  logic [2:0] rec_alarm, alarm_flags;
  logic [31:0] rec_stamp;
  logic [1:0] profile_count, profile_sel;
  logic [6:0] reg_addr;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  vrs_record_store u_vrs_record_store (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .record_control(record_control), .temp_in(temp_in), .supply_in(supply_in),
    .cap_start(cap_start), .cap_we(cap_we), .cap_index(cap_index), .cap_accel(cap_accel), .cap_vel(cap_vel),
    .cap_rss(cap_rss), .rec_done(rec_done), .rec_alarm(rec_alarm), .hdr_word1(hdr_word1),
    .hdr_word2(hdr_word2), .rec_stamp(rec_stamp), .profile_count(profile_count), .busy(busy),
    .profile_sel(profile_sel), .alarm_flags(alarm_flags));
  vrs_host_model u_vrs_host_model (.clk_sys(clk_sys), .busy(busy), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ----------
  // helpers
  // ----------
  function automatic logic [15:0] val(input int a, input logic [11:0] i, input logic [3:0] k);
    return {k, 2'(a), i[9:0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rc(input string nm, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_vrs_host_model.rd(a, d);
    chk(nm, d, exp);
  endtask
  // sparse fill keeps the run short; untouched bins are never compared
  task automatic rec(input logic [15:0] ctrl, input logic [3:0] k, input logic [2:0] al, input logic arch,
    input string nm);
    logic [11:0] ix [3] = '{12'h000, 12'h001, 12'hFFF};
    int n;
    @(posedge clk_sys);
    record_control <= ctrl;
    foreach (ix[j]) begin
      @(posedge clk_sys);
      cap_we <= 1'b1;
      cap_index <= ix[j];
      cap_rss <= val(3, ix[j], k);
      for (int a = 0; a < 3; a++) begin
        cap_accel[a] <= val(a, ix[j], k);
        cap_vel[a] <= ~val(a, ix[j], k);
      end
    end
    @(posedge clk_sys);
    cap_we <= 1'b0;
    rec_done <= 1'b1;
    rec_alarm <= al;
    hdr_word1 <= {12'h000, k};
    hdr_word2 <= {k, 12'h000};
    rec_stamp <= {16'h0000, k, 12'h000};
    @(posedge clk_sys);
    rec_done <= 1'b0;
    u_vrs_host_model.wait_ready(n);
    chk(nm, {14'h0000, n >= 3000, n > 100}, {14'h0000, 1'b0, arch});
  endtask
  task automatic restore(input logic [15:0] sel);
    int n;
    u_vrs_host_model.wr(ADDR_RECORD_SELECTOR, sel);
    u_vrs_host_model.wr(ADDR_GLOBAL_COMMAND, 16'h2000);
    u_vrs_host_model.wait_ready(n);
    chk("restore", {14'h0000, n >= 3000, n > 100}, 16'h0001);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    {srst, ce} = 2'h3;
    {cap_start, cap_we, rec_done, rec_alarm} = 6'h00;
    {record_control, cap_rss, hdr_word1, hdr_word2, rec_stamp} = '0;
    {cap_index, cap_accel, cap_vel} = '0;
    {temp_in, supply_in, profile_count} = {16'h1234, 16'h5678, 2'h1};
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rc("index", ADDR_BUFFER_INDEX, INDEX_RESET);
    rc("selector", ADDR_RECORD_SELECTOR, SELECTOR_RESET);
    rc("x_out", ADDR_X_SAMPLE_OUT, SAMPLE_RESET);
    rc("command", ADDR_GLOBAL_COMMAND, 16'h0000);
    u_vrs_host_model.wr(ADDR_RECORD_SELECTOR, 16'hFFFF);
    rc("selector", ADDR_RECORD_SELECTOR, SELECTOR_MASK);
    u_vrs_host_model.wr(ADDR_RECORD_SELECTOR, 16'h0000);
    rec(16'h0122, 4'h1, 3'h0, 1'b0, "time_rec");
    rc("index", ADDR_BUFFER_INDEX, 16'h0000);
    rc("x_out", ADDR_X_SAMPLE_OUT, ~val(0, 12'h000, 4'h1));
    rc("y_out", ADDR_Y_SAMPLE_OUT, ~val(1, 12'h001, 4'h1));
    u_vrs_host_model.wr(ADDR_BUFFER_INDEX, 16'hF000);
    rc("z_out", ADDR_Z_SAMPLE_OUT, val(3, 12'h000, 4'h1));
    rc("index", ADDR_BUFFER_INDEX, 16'h0001);
    u_vrs_host_model.wr(ADDR_BUFFER_INDEX, 16'hFFFF);
    rc("x_out", ADDR_X_SAMPLE_OUT, ~val(0, 12'hFFF, 4'h1));
    rc("index", ADDR_BUFFER_INDEX, {4'h0, TIME_LAST});
    rec(16'h0046, 4'h8, 3'h1, 1'b0, "stat_rec");
    rec(16'h0002, 4'h2, 3'h1, 1'b0, "time_acc");
    rc("x_out", ADDR_X_SAMPLE_OUT, val(0, 12'h000, 4'h2));
    rc("stat_info", ADDR_RECORD_HEADER_FIRST, 16'h0008);
    rec(16'h000A, 4'h6, 3'h2, 1'b0, "time_all");
    rec(16'h0004, 4'h3, 3'h4, 1'b1, "alarm_rec");
    u_vrs_host_model.wr(ADDR_BUFFER_INDEX, 16'h0FFF);
    rc("index", ADDR_BUFFER_INDEX, {4'h0, SPEC_LAST});
    rec(16'h0004, 4'h4, 3'h0, 1'b0, "quiet_rec");
    rc("x_out", ADDR_X_SAMPLE_OUT, val(0, 12'h000, 4'h4));
    rec(16'h0009, 4'h5, 3'h0, 1'b1, "all_rec");
    rec(16'h000B, 4'h7, 3'h0, 1'b0, "stream_rec");
    restore(16'h0000);
    rc("x_out", ADDR_X_SAMPLE_OUT, val(0, 12'h000, 4'h3));
    rc("y_out", ADDR_Y_SAMPLE_OUT, val(1, 12'h001, 4'h3));
    rc("info_first", ADDR_RECORD_HEADER_FIRST, 16'h0003);
    rc("stamp_low", ADDR_TIMESTAMP_LOW, 16'h3000);
    restore(16'h0001);
    rc("x_out", ADDR_X_SAMPLE_OUT, val(0, 12'h000, 4'h5));
    u_vrs_host_model.wr(ADDR_RECORD_SELECTOR, 16'h000A);
    u_vrs_host_model.wr(ADDR_GLOBAL_COMMAND, 16'h2000);
    @(posedge clk_sys);
    chk("busy", {15'h0000, busy}, 16'h0001);
    end_of_test();
  end
endmodule
